/* eeprom_ctrl_pkg.sv */
package eeprom_ctrl_pkg;
    // special function addresses
    localparam logic [7:0] sfr_dp0_lo   = 8'h82;
    localparam logic [7:0] sfr_dp0_hi   = 8'h83;
    localparam logic [7:0] sfr_dp1_lo   = 8'h84;
    localparam logic [7:0] sfr_dp1_hi   = 8'h85;
    localparam logic [7:0] sfr_eeprom_control    = 8'h96;
    localparam logic [7:0] ram_low_top  = 8'h7f;
    // control register field positions
    localparam int bit_load_only   = 5;
    localparam int bit_write_en    = 4;
    localparam int bit_ee_select   = 3;
    localparam int bit_bank_select = 2;
    localparam int bit_ready       = 1;
    localparam int bit_supply_ok   = 0;
    localparam logic [7:0] eeprom_control_reset = 8'h03;
    localparam logic [7:0] eeprom_control_wmask = 8'h3c;
    // memory geometry
    localparam int ee_bytes    = 2048;
    localparam int ee_aw       = 11;
    localparam int ram_bytes   = 256;
    localparam int page_bytes  = 32;
    localparam int page_aw     = 5;
    localparam logic [15:0] ee_limit = 16'h0800;
    // programming time
    localparam int clk_mhz      = 100;
    localparam int prog_time_ms = 4;
    localparam int prog_cycles  = prog_time_ms * 1000 * clk_mhz;
    localparam logic [7:0] msb_flip = 8'h80;
    // programming engine states
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_prog = 2'b01,
        st_done = 2'b10
    } prog_state_t;
endpackage : eeprom_ctrl_pkg

/* byte_mem.sv */
`timescale 1ns/1ns
`default_nettype none
// single-port byte memory with registered read data
module byte_mem #(
    parameter int depth = 256,
    parameter int aw    = 8
) (
    // clock
    input  wire logic          sys_clk,
    // access
    input  wire logic          we,
    input  wire logic [aw-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata
);
    logic [7:0] mem [depth];

    // no reset on the array, contents survive reset
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule : byte_mem
`default_nettype wire

/* data_eeprom_access_control.sv */
`timescale 1ns/1ns
`default_nettype none
// Function
// - provides 2K EEPROM data bytes and 256 internal RAM bytes.
// - direct accesses above 7FH reach special function space.
// - indirect accesses above 7FH reach upper 128 RAM bytes.
// - stack push and pop count as indirect accesses.
// - eeprom_select in control register 96H routes external moves to EEPROM.
// - EEPROM answers addresses 000H to 7FFH.
// - eeprom_select clear sends external moves off chip.
// - byte write erases and rewrites only the addressed byte.
// - EEPROM writes accepted only while eeprom_write_enable is 1.
// - programming is self-timed, nominally 4 ms.
// - eeprom_ready_flag reads 0 while programming, 1 when done.
// - buffer_load_only set makes writes only fill the page buffer.
// - clear buffer_load_only before final move; whole page then programs.
// - full page programs in one 4 ms interval, not 128 ms.
// - reads of the final move's byte during programming return it with MSB inverted.
// - after programming, reads return true data.
// - two 16-bit pointer banks at 82H-83H and 84H-85H.
// - pointer_bank_select picks bank zero or bank one.
// - active pointer addresses 2K and above go off chip.
// - supply low aborts programming and blocks new cycles.
// - ready flag drops after the initiating move completes.
// - page programs into page of final move's address.
module data_eeprom_access_control #(
    parameter int prog_cycles = eeprom_ctrl_pkg::prog_cycles
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // internal data space access from the core
    input  wire logic        int_req,
    input  wire logic        int_we,
    input  wire logic        int_indirect,
    input  wire logic [7:0]  int_addr,
    input  wire logic [7:0]  int_wdata,
    output logic      [7:0]  int_rdata,
    output logic             int_ack,
    output logic             int_to_sfr,
    // external move through the active data pointer
    input  wire logic        xm_req,
    input  wire logic        xm_we,
    input  wire logic [7:0]  xm_wdata,
    output logic      [7:0]  xm_rdata,
    output logic             xm_ack,
    // off-chip data memory
    output logic             ext_req,
    output logic             ext_we,
    output logic      [15:0] ext_addr,
    output logic      [7:0]  ext_wdata,
    // supply monitor, high while supply allows programming
    input  wire logic        supply_ok
);
    // register state
    logic [15:0] dp0_q, dp0_d, dp1_q, dp1_d;
    logic [7:0]  ctrl_q, ctrl_d;
    eeprom_ctrl_pkg::prog_state_t st_q, st_d;
    logic [31:0] cnt_q, cnt_d;
    logic [7:0]  pbuf_q [eeprom_ctrl_pkg::page_bytes];
    logic [7:0]  pbuf_d [eeprom_ctrl_pkg::page_bytes];
    logic [eeprom_ctrl_pkg::page_bytes-1:0] pval_q, pval_d;
    logic [eeprom_ctrl_pkg::ee_aw-1:0] paddr_q, paddr_d;
    logic [eeprom_ctrl_pkg::page_aw:0] widx_q, widx_d;
    logic [7:0]  last_q, last_d;
    logic [eeprom_ctrl_pkg::ee_aw-1:0] last_a_q, last_a_d;
    logic        start_q, start_d;
    // registered outputs
    logic [7:0]  int_rdata_q, int_rdata_d, xm_rdata_q, xm_rdata_d;
    logic        int_ack_q, int_ack_d, int_sfr_q, int_sfr_d, xm_ack_q, xm_ack_d;
    logic        ext_req_q, ext_req_d, ext_we_q, ext_we_d;
    logic [15:0] ext_addr_q, ext_addr_d;
    logic [7:0]  ext_wd_q, ext_wd_d;
    // pending reads resolved one cycle later
    logic        ram_rd_q, ram_rd_d, ee_rd_q, ee_rd_d;
    logic        ee_rd_busy_q, ee_rd_busy_d, ee_rd_hit_q, ee_rd_hit_d;
    logic [7:0]  ee_hit_byte_q, ee_hit_byte_d;
    // memory ports
    logic        ram_we, ee_we;
    logic [7:0]  ram_addr, ram_rdata, ee_rdata, ee_wdata;
    logic [eeprom_ctrl_pkg::ee_aw-1:0] ee_addr;
    logic [15:0] active_data_pointer;
    logic        to_ee;

    // choose the live pointer bank
    function automatic logic [15:0] pick_ptr(input logic sel, input logic [15:0] a,
                                             input logic [15:0] b);
        pick_ptr = sel ? b : a;
    endfunction : pick_ptr

    // direct above 7FH is special function space
    function automatic logic is_sfr(input logic ind, input logic [7:0] a);
        is_sfr = !ind && (a > eeprom_ctrl_pkg::ram_low_top);
    endfunction : is_sfr

    assign active_data_pointer  = pick_ptr(ctrl_q[eeprom_ctrl_pkg::bit_bank_select], dp0_q, dp1_q);
    assign to_ee = ctrl_q[eeprom_ctrl_pkg::bit_ee_select] && (active_data_pointer < eeprom_ctrl_pkg::ee_limit);

    byte_mem #(.depth(eeprom_ctrl_pkg::ram_bytes), .aw(8)) u_ram (
        .sys_clk (sys_clk),
        .we      (ram_we),
        .addr    (ram_addr),
        .wdata   (int_wdata),
        .rdata   (ram_rdata)
    );

    byte_mem #(.depth(eeprom_ctrl_pkg::ee_bytes), .aw(eeprom_ctrl_pkg::ee_aw)) u_ee (
        .sys_clk (sys_clk),
        .we      (ee_we),
        .addr    (ee_addr),
        .wdata   (ee_wdata),
        .rdata   (ee_rdata)
    );

    // indirect and stack accesses use RAM, stack counts as indirect
    assign ram_addr = int_addr;
    assign ram_we   = int_req && int_we && !is_sfr(int_indirect, int_addr);

    // the engine writes one buffered byte per cycle, other bytes untouched
    assign ee_we    = (st_q == eeprom_ctrl_pkg::st_done) && pval_q[widx_q[eeprom_ctrl_pkg::page_aw-1:0]]
                      && !widx_q[eeprom_ctrl_pkg::page_aw];
    assign ee_wdata = pbuf_q[widx_q[eeprom_ctrl_pkg::page_aw-1:0]];
    assign ee_addr  = ee_we ? {paddr_q[eeprom_ctrl_pkg::ee_aw-1:eeprom_ctrl_pkg::page_aw],
                               widx_q[eeprom_ctrl_pkg::page_aw-1:0]}
                            : active_data_pointer[eeprom_ctrl_pkg::ee_aw-1:0];

    // register file, bus routing and programming engine next state
    always_comb begin
        logic [eeprom_ctrl_pkg::page_aw-1:0] off;
        off = active_data_pointer[eeprom_ctrl_pkg::page_aw-1:0];
        dp0_d = dp0_q;
        dp1_d = dp1_q;
        ctrl_d = ctrl_q;
        st_d = st_q;
        cnt_d = cnt_q;
        pbuf_d = pbuf_q;
        pval_d = pval_q;
        paddr_d = paddr_q;
        widx_d = widx_q;
        last_d = last_q;
        last_a_d = last_a_q;
        start_d = 1'b0;
        int_rdata_d = int_rdata_q;
        int_ack_d = 1'b0;
        int_sfr_d = 1'b0;
        xm_rdata_d = xm_rdata_q;
        xm_ack_d = 1'b0;
        ext_req_d = 1'b0;
        ext_we_d = 1'b0;
        ext_addr_d = ext_addr_q;
        ext_wd_d = ext_wd_q;
        ram_rd_d = 1'b0;
        ee_rd_d = 1'b0;
        ee_rd_busy_d = 1'b0;
        ee_rd_hit_d = 1'b0;
        ee_hit_byte_d = ee_hit_byte_q;
        // read-only status bits follow hardware
        ctrl_d[eeprom_ctrl_pkg::bit_supply_ok] = supply_ok;
        // finish reads issued last cycle
        if (ram_rd_q) begin
            int_rdata_d = ram_rdata;
            int_ack_d = 1'b1;
        end
        if (ee_rd_q) begin
            // busy read of the byte in flight flips its MSB
            if (ee_rd_busy_q && ee_rd_hit_q) begin
                xm_rdata_d = ee_hit_byte_q ^ eeprom_ctrl_pkg::msb_flip;
            end else begin
                xm_rdata_d = ee_rdata;
            end
            xm_ack_d = 1'b1;
        end
        // internal data space access
        if (int_req) begin
            if (is_sfr(int_indirect, int_addr)) begin
                int_sfr_d = 1'b1;
                int_ack_d = 1'b1;
                int_rdata_d = 8'h00;
                // pointer banks and control register decode
                case (int_addr)
                    eeprom_ctrl_pkg::sfr_dp0_lo: begin
                        int_rdata_d = dp0_q[7:0];
                        if (int_we) dp0_d[7:0] = int_wdata;
                    end
                    eeprom_ctrl_pkg::sfr_dp0_hi: begin
                        int_rdata_d = dp0_q[15:8];
                        if (int_we) dp0_d[15:8] = int_wdata;
                    end
                    eeprom_ctrl_pkg::sfr_dp1_lo: begin
                        int_rdata_d = dp1_q[7:0];
                        if (int_we) dp1_d[7:0] = int_wdata;
                    end
                    eeprom_ctrl_pkg::sfr_dp1_hi: begin
                        int_rdata_d = dp1_q[15:8];
                        if (int_we) dp1_d[15:8] = int_wdata;
                    end
                    eeprom_ctrl_pkg::sfr_eeprom_control: begin
                        int_rdata_d = ctrl_q;
                        if (int_we) begin
                            // only bits 5..2 are writable
                            ctrl_d = (ctrl_d & ~eeprom_ctrl_pkg::eeprom_control_wmask)
                                     | (int_wdata & eeprom_ctrl_pkg::eeprom_control_wmask);
                        end
                    end
                    default: int_rdata_d = 8'h00;
                endcase
            end else if (int_we) begin
                int_ack_d = 1'b1;
            end else begin
                ram_rd_d = 1'b1;
            end
        end
        // external move
        if (xm_req) begin
            if (to_ee) begin
                if (xm_we) begin
                    xm_ack_d = 1'b1;
                    // write enable gate, no start while supply low
                    if (ctrl_q[eeprom_ctrl_pkg::bit_write_en] && supply_ok
                        && st_q == eeprom_ctrl_pkg::st_idle) begin
                        pbuf_d[off] = xm_wdata;
                        pval_d[off] = 1'b1;
                        if (!ctrl_q[eeprom_ctrl_pkg::bit_load_only]) begin
                            // page from final move, program page together
                            paddr_d = active_data_pointer[eeprom_ctrl_pkg::ee_aw-1:0];
                            last_d = xm_wdata;
                            last_a_d = active_data_pointer[eeprom_ctrl_pkg::ee_aw-1:0];
                            start_d = 1'b1;
                        end
                    end
                end else begin
                    ee_rd_d = 1'b1;
                    ee_rd_busy_d = (st_q != eeprom_ctrl_pkg::st_idle);
                    ee_rd_hit_d = (active_data_pointer[eeprom_ctrl_pkg::ee_aw-1:0] == last_a_q);
                    ee_hit_byte_d = last_q;
                end
            end else begin
                ext_req_d = 1'b1;
                ext_we_d = xm_we;
                ext_addr_d = active_data_pointer;
                ext_wd_d = xm_wdata;
                xm_ack_d = 1'b1;
            end
        end
        // programming engine
        case (st_q)
            eeprom_ctrl_pkg::st_idle: begin
                // busy taken the cycle after the move was acknowledged
                if (start_q) begin
                    st_d = eeprom_ctrl_pkg::st_prog;
                    cnt_d = 32'h0;
                    ctrl_d[eeprom_ctrl_pkg::bit_ready] = 1'b0;
                end
            end
            eeprom_ctrl_pkg::st_prog: begin
                // self-timed interval, one interval per page, counter
                if (cnt_q >= 32'(prog_cycles - 1)) begin
                    st_d = eeprom_ctrl_pkg::st_done;
                    widx_d = '0;
                end else begin
                    cnt_d = cnt_q + 32'h1;
                end
            end
            eeprom_ctrl_pkg::st_done: begin
                // commit buffered bytes one per cycle
                if (widx_q[eeprom_ctrl_pkg::page_aw]) begin
                    st_d = eeprom_ctrl_pkg::st_idle;
                    pval_d = '0;
                    ctrl_d[eeprom_ctrl_pkg::bit_ready] = 1'b1;
                end else begin
                    widx_d = widx_q + 1'b1;
                end
            end
            default: st_d = eeprom_ctrl_pkg::st_idle;
        endcase
        // supply low aborts the cycle, buffer dropped
        if (!supply_ok && st_q != eeprom_ctrl_pkg::st_idle) begin
            st_d = eeprom_ctrl_pkg::st_idle;
            pval_d = '0;
            ctrl_d[eeprom_ctrl_pkg::bit_ready] = 1'b1;
        end
    end

    // state registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dp0_q <= 16'h0000;
            dp1_q <= 16'h0000;
            ctrl_q <= eeprom_ctrl_pkg::eeprom_control_reset;
            st_q <= eeprom_ctrl_pkg::st_idle;
            cnt_q <= 32'h0;
            pbuf_q <= '{default: 8'h00};
            pval_q <= '0;
            paddr_q <= '0;
            widx_q <= '0;
            last_q <= 8'h00;
            last_a_q <= '0;
            start_q <= 1'b0;
            int_rdata_q <= 8'h00;
            int_ack_q <= 1'b0;
            int_sfr_q <= 1'b0;
            xm_rdata_q <= 8'h00;
            xm_ack_q <= 1'b0;
            ext_req_q <= 1'b0;
            ext_we_q <= 1'b0;
            ext_addr_q <= 16'h0000;
            ext_wd_q <= 8'h00;
            ram_rd_q <= 1'b0;
            ee_rd_q <= 1'b0;
            ee_rd_busy_q <= 1'b0;
            ee_rd_hit_q <= 1'b0;
            ee_hit_byte_q <= 8'h00;
        end else begin
            dp0_q <= dp0_d;
            dp1_q <= dp1_d;
            ctrl_q <= ctrl_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            pbuf_q <= pbuf_d;
            pval_q <= pval_d;
            paddr_q <= paddr_d;
            widx_q <= widx_d;
            last_q <= last_d;
            last_a_q <= last_a_d;
            start_q <= start_d;
            int_rdata_q <= int_rdata_d;
            int_ack_q <= int_ack_d;
            int_sfr_q <= int_sfr_d;
            xm_rdata_q <= xm_rdata_d;
            xm_ack_q <= xm_ack_d;
            ext_req_q <= ext_req_d;
            ext_we_q <= ext_we_d;
            ext_addr_q <= ext_addr_d;
            ext_wd_q <= ext_wd_d;
            ram_rd_q <= ram_rd_d;
            ee_rd_q <= ee_rd_d;
            ee_rd_busy_q <= ee_rd_busy_d;
            ee_rd_hit_q <= ee_rd_hit_d;
            ee_hit_byte_q <= ee_hit_byte_d;
        end
    end

    // outputs straight from flops
    assign int_rdata  = int_rdata_q;
    assign int_ack    = int_ack_q;
    assign int_to_sfr = int_sfr_q;
    assign xm_rdata   = xm_rdata_q;
    assign xm_ack     = xm_ack_q;
    assign ext_req    = ext_req_q;
    assign ext_we     = ext_we_q;
    assign ext_addr   = ext_addr_q;
    assign ext_wdata  = ext_wd_q;
endmodule : data_eeprom_access_control
`default_nettype wire

/* eeprom_access_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
// watches routing and answer timing at the block's ports
module eeprom_access_asserts #(
    parameter int prog_cycles = 20
) (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        reset,
    // core side
    input wire logic        int_req,
    input wire logic        int_we,
    input wire logic        int_indirect,
    input wire logic [7:0]  int_addr,
    input wire logic        int_ack,
    input wire logic        int_to_sfr,
    input wire logic        xm_req,
    input wire logic        xm_we,
    input wire logic [7:0]  xm_wdata,
    input wire logic        xm_ack,
    // off-chip side
    input wire logic        ext_req,
    input wire logic        ext_we,
    input wire logic [15:0] ext_addr,
    input wire logic [7:0]  ext_wdata
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // answers are tied to their requests with exact latencies
    AST_SFR_DIRECT: assert property (int_req && !int_indirect && int_addr > 8'h7f
        |=> int_ack && int_to_sfr) else $error("direct high access missed sfr space");
    AST_RAM_INDIRECT: assert property (int_req && int_indirect && !int_we
        |=> !int_to_sfr ##1 (int_ack && !int_to_sfr)) else $error("indirect read misrouted");
    AST_RAM_WRITE: assert property (int_req && int_indirect && int_we
        |=> int_ack && !int_to_sfr) else $error("indirect write answer wrong");
    AST_ACK_CAUSE: assert property (int_ack
        |-> $past(int_req) || $past(int_req, 2)) else $error("internal ack without request");
    AST_XM_WR_ACK: assert property (xm_req && xm_we
        |=> xm_ack) else $error("move write not answered next cycle");
    AST_EXT_DATA: assert property (ext_req && ext_we
        |-> $past(xm_req) && ext_wdata == $past(xm_wdata)) else $error("off-chip data wrong");
    AST_EXT_ACK: assert property (ext_req
        |-> xm_ack) else $error("off-chip access without move answer");
    AST_EXT_HOLD: assert property (!ext_req
        |-> $stable(ext_addr)) else $error("off-chip address moved while idle");
endmodule : eeprom_access_asserts

bind data_eeprom_access_control eeprom_access_asserts #(.prog_cycles(prog_cycles)) chk_inst (
    .sys_clk, .reset, .int_req, .int_we, .int_indirect, .int_addr, .int_ack, .int_to_sfr,
    .xm_req, .xm_we, .xm_wdata, .xm_ack, .ext_req, .ext_we, .ext_addr, .ext_wdata);
`default_nettype wire

/* offchip_mem.sv */
`timescale 1ns/1ns
`default_nettype none
// off-chip data memory stand-in; keeps only the last write it saw
module offchip_mem (
    // bus from the block
    input wire logic        sys_clk,
    input wire logic        ext_req,
    input wire logic        ext_we,
    input wire logic [15:0] ext_addr,
    input wire logic [7:0]  ext_wdata,
    // what the bench inspects
    output logic     [15:0] seen_addr,
    output logic     [7:0]  seen_data
);
    always_ff @(posedge sys_clk) begin
        if (ext_req && ext_we) begin
            seen_addr <= ext_addr;
            seen_data <= ext_wdata;
        end
    end
endmodule : offchip_mem
`default_nettype wire

/* tb_data_eeprom_access_control.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_data_eeprom_access_control;
    localparam int pc = 20;
    logic        sys_clk, reset, supply_ok, int_req, int_we, int_indirect, int_ack, int_to_sfr;
    logic        xm_req, xm_we, xm_ack, ext_req, ext_we, rs;
    logic [7:0]  int_addr, int_wdata, int_rdata, xm_wdata, xm_rdata, ext_wdata, sd, rd, b, c;
    logic [15:0] ext_addr, sa;
    logic [31:0] seed;
    logic [7:0]  pg [32];
    int          fails, checks_done, cyc, n;

    data_eeprom_access_control #(.prog_cycles(pc)) data_eeprom_access_control_inst (
        .sys_clk, .reset, .int_req, .int_we, .int_indirect, .int_addr, .int_wdata,
        .int_rdata, .int_ack, .int_to_sfr, .xm_req, .xm_we, .xm_wdata, .xm_rdata, .xm_ack,
        .ext_req, .ext_we, .ext_addr, .ext_wdata, .supply_ok);
    offchip_mem offchip_mem_inst (.sys_clk, .ext_req, .ext_we, .ext_addr, .ext_wdata,
        .seen_addr(sa), .seen_data(sd));

    // free-running 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // xorshift source for data bytes, repeatable from its seed
    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : xs

    // control byte from its fields
    function automatic logic [7:0] ctl(input logic ld, we, sel, bank);
        return {2'b00, ld, we, sel, bank, 2'b00};
    endfunction : ctl

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done

    // one-cycle request, then a bounded wait for the answer pulse
    task automatic int_acc(input logic w, ind, input logic [7:0] a, d);
        int_req      = 1'b1;
        int_we       = w;
        int_indirect = ind;
        int_addr     = a;
        int_wdata    = d;
        @(negedge sys_clk);
        int_req = 1'b0;
        for (int k = 0; k < 3 && int_ack !== 1'b1; k++) @(negedge sys_clk);
        check({7'h00, int_ack}, 8'h01);
        rd = int_rdata;
        rs = int_to_sfr;
    endtask : int_acc

    task automatic xm_acc(input logic w, input logic [7:0] d);
        xm_req   = 1'b1;
        xm_we    = w;
        xm_wdata = d;
        @(negedge sys_clk);
        xm_req = 1'b0;
        for (int k = 0; k < 3 && xm_ack !== 1'b1; k++) @(negedge sys_clk);
        check({7'h00, xm_ack}, 8'h01);
        rd = xm_rdata;
    endtask : xm_acc

    task automatic set_ptr(input logic bank, input logic [15:0] v);
        int_acc(1'b1, 1'b0, bank ? 8'h84 : 8'h82, v[7:0]);
        int_acc(1'b1, 1'b0, bank ? 8'h85 : 8'h83, v[15:8]);
    endtask : set_ptr

    task automatic set_ctl(input logic ld, we, sel, bank);
        int_acc(1'b1, 1'b0, eeprom_ctrl_pkg::sfr_eeprom_control, ctl(ld, we, sel, bank));
    endtask : set_ctl

    // polls the ready bit; each poll costs one cycle, first poll after busy is visible
    task automatic wait_ready();
        n = 0;
        @(negedge sys_clk);
        do begin
            int_acc(1'b0, 1'b0, eeprom_ctrl_pkg::sfr_eeprom_control, 8'h00);
            n++;
        end while (rd[1] !== 1'b1 && n < 200);
    endtask : wait_ready

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            test_done();
        end
    end

    initial begin
        {int_req, int_we, int_indirect, xm_req, xm_we} = 5'h00;
        {int_addr, int_wdata, xm_wdata} = 24'h000000;
        {fails, checks_done, cyc} = '0;
        seed      = 32'd40;
        supply_ok = 1'b1;
        reset     = 1'b1;
        repeat (4) @(negedge sys_clk);
        reset = 1'b0;
        int_acc(1'b0, 1'b0, eeprom_ctrl_pkg::sfr_eeprom_control, 8'h00);
        check(rd, eeprom_ctrl_pkg::eeprom_control_reset);
        for (int i = 0; i < 4; i++) begin
            int_acc(1'b0, 1'b0, eeprom_ctrl_pkg::sfr_dp0_lo + 8'(i), 8'h00);
            check(rd, 8'h00);
        end
        b = xs();
        c = xs();
        set_ptr(1'b0, {b, c});
        set_ptr(1'b1, {c, b});
        for (int i = 0; i < 4; i++) begin
            int_acc(1'b0, 1'b0, eeprom_ctrl_pkg::sfr_dp0_lo + 8'(i), 8'h00);
            check(rd, i[0] ^ i[1] ? b : c);
        end
        $display("test pointers done");
        b = xs();
        int_acc(1'b1, 1'b1, 8'ha0, b);
        int_acc(1'b1, 1'b0, 8'ha0, ~b);
        int_acc(1'b0, 1'b1, 8'ha0, 8'h00);
        check(rd, b);
        check({7'h00, rs}, 8'h00);
        int_acc(1'b0, 1'b0, 8'ha0, 8'h00);
        check(rd, 8'h00);
        check({7'h00, rs}, 8'h01);
        int_acc(1'b1, 1'b0, eeprom_ctrl_pkg::ram_low_top, c);
        int_acc(1'b0, 1'b1, eeprom_ctrl_pkg::ram_low_top, 8'h00);
        check(rd, c);
        $display("test ram routing done");
        // off-chip through bank one, then at 2K
        set_ctl(1'b0, 1'b0, 1'b0, 1'b1);
        xm_acc(1'b1, b);
        @(negedge sys_clk);
        check(sa[15:8], c);
        check(sd, b);
        set_ctl(1'b0, 1'b0, 1'b1, 1'b0);
        set_ptr(1'b0, eeprom_ctrl_pkg::ee_limit);
        xm_acc(1'b1, c);
        @(negedge sys_clk);
        check(sa[15:8], 8'h08);
        check(sd, c);
        $display("test off-chip done");
        // byte writes at the top of the range
        set_ctl(1'b0, 1'b1, 1'b1, 1'b0);
        b = xs();
        c = xs();
        set_ptr(1'b0, 16'h07fe);
        xm_acc(1'b1, b);
        wait_ready();
        set_ptr(1'b0, 16'h07ff);
        xm_acc(1'b1, c);
        @(negedge sys_clk);
        int_acc(1'b0, 1'b0, eeprom_ctrl_pkg::sfr_eeprom_control, 8'h00);
        check({7'h00, rd[1]}, 8'h00);
        xm_acc(1'b0, 8'h00);
        check(rd, c ^ eeprom_ctrl_pkg::msb_flip);
        wait_ready();
        check({7'h00, n > pc / 2}, 8'h01);
        xm_acc(1'b0, 8'h00);
        check(rd, c);
        set_ptr(1'b0, 16'h07fe);
        xm_acc(1'b0, 8'h00);
        check(rd, b);
        check(sa[15:8], 8'h08);
        set_ctl(1'b0, 1'b0, 1'b1, 1'b0);
        xm_acc(1'b1, ~b);
        xm_acc(1'b0, 8'h00);
        check(rd, b);
        $display("test byte write done");
        // page loaded at one page, committed at another
        set_ctl(1'b1, 1'b1, 1'b1, 1'b0);
        set_ptr(1'b0, 16'h0020);
        for (int i = 0; i < 32; i++) begin
            pg[i] = xs();
            if (i == 31) set_ctl(1'b0, 1'b1, 1'b1, 1'b0);
            int_acc(1'b1, 1'b0, eeprom_ctrl_pkg::sfr_dp0_lo, 8'(i + (i == 31 ? 64 : 32)));
            xm_acc(1'b1, pg[i]);
            if (i == 30) wait_ready();
            if (i == 30) check(8'(n), 8'h01);
        end
        wait_ready();
        check({7'h00, n > pc && n < 3 * pc + 32}, 8'h01);
        for (int i = 0; i < 32; i++) begin
            int_acc(1'b1, 1'b0, eeprom_ctrl_pkg::sfr_dp0_lo, 8'(i + 64));
            xm_acc(1'b0, 8'h00);
            check(rd, pg[i]);
        end
        $display("test page write done");
        xm_acc(1'b1, 8'h5a);
        supply_ok = 1'b0;
        repeat (3) @(negedge sys_clk);
        int_acc(1'b0, 1'b0, eeprom_ctrl_pkg::sfr_eeprom_control, 8'h00);
        check({6'h00, rd[1:0]}, 8'h02);
        xm_acc(1'b1, 8'ha5);
        repeat (2) @(negedge sys_clk);
        int_acc(1'b0, 1'b0, eeprom_ctrl_pkg::sfr_eeprom_control, 8'h00);
        check({6'h00, rd[1:0]}, 8'h02);
        supply_ok = 1'b1;
        xm_acc(1'b0, 8'h00);
        check(rd, pg[31]);
        // software drops write enable when finished
        set_ctl(1'b0, 1'b0, 1'b0, 1'b0);
        $display("test supply done");
        test_done();
    end
endmodule : tb_data_eeprom_access_control
`default_nettype wire
